// File: logic/rsu_pkg.sv
// rsu package: constants, types and helpers of the upgrade sequencer
package rsu_pkg;

   // ----------------------------------------
   // control and update register layout
   // ----------------------------------------
   typedef struct packed {
      logic rsv2;                  // reserved high bit
      logic early_done_check_opt;  // early done check option
      logic osc_int;               // internal startup clock option
      logic wd_en;                 // watchdog enable
      logic rsv1;                  // reserved low bit
      logic [21:0] ru_address;     // upper boot address bits
      logic [11:0] wd_timer;       // upper watchdog bits
   } rsu_ctl_t;

   // cause field, bit 4 is the highest priority
   typedef struct packed {
      logic ext;   // external configuration reset
      logic crc;   // crc error during load
      logic pin;   // error pin asserted
      logic wd;    // user watchdog expiry
      logic fab;   // fabric reconfiguration request
   } rsu_cause_t;

   // previous-state record, 31 bits
   typedef struct packed {
      rsu_cause_t cause;      // bits 30:26
      logic [1:0] mstate;     // bits 25:24
      logic [23:0] boot;      // bits 23:0
   } rsu_rec_t;

   // ----------------------------------------
   // constants
   // ----------------------------------------
   localparam rsu_ctl_t CTL_RESET = '0;      // control after error
   localparam rsu_ctl_t UPD_RESET = '0;      // update after reset
   localparam logic [1:0] MS_FACTORY = 2'h1; // factory image running
   localparam logic [1:0] MS_APP = 2'h2;     // application running
   localparam logic [16:0] WD_LOW = 17'h00008; // appended timeout bits
   localparam logic [1:0] ADDR_LOW = 2'h0;   // boot address low bits
   localparam logic [5:0] PAD6 = 6'h00;      // readout padding
   localparam logic [26:0] PAD27 = 27'h0000000; // cause word padding
   localparam logic [31:0] INVALID_WORD = 32'hffffffff; // bad capture
   localparam logic [4:0] CAUSE_NONE = 5'h00; // no cause yet

   // readout selectors
   localparam logic [2:0] SEL_CUR1 = 3'h0;   // current readout one
   localparam logic [2:0] SEL_CUR2 = 3'h1;   // current readout two
   localparam logic [2:0] SEL_PREV1 = 3'h2;  // record of this app
   localparam logic [2:0] SEL_PREV2 = 3'h3;  // record of app before
   localparam logic [2:0] SEL_CAUSE = 3'h4;  // status register cause

   // request hold time
   localparam int CLK_PERIOD_NS = 20;
   localparam int REQ_HOLD_NS = 250;
   localparam int REQ_HOLD_CYC =
      (REQ_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] HOLD_LAST = 4'(REQ_HOLD_CYC - 1);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // full boot address from the stored upper bits
   function automatic logic [23:0] boot_of(input rsu_ctl_t c);
      return {c.ru_address, ADDR_LOW};
   endfunction

   // full watchdog timeout from the stored timer bits
   function automatic logic [28:0] wd_value(input rsu_ctl_t c);
      return {c.wd_timer, WD_LOW};
   endfunction

   // keep only the highest set cause bit
   function automatic rsu_cause_t pick_cause(input rsu_cause_t raw);
      logic [4:0] v;
      logic [4:0] w;
      v = raw;
      w = CAUSE_NONE;
      for (int i = 0; i < 5; i++) begin
         if (v[i]) begin
            w = 5'h01 << i;
         end
      end
      return w;
   endfunction

endpackage

// File: logic/rsu_rec_mem.sv
// rsu record store: two previous-state records with registered read
`timescale 1ns/100ps
module rsu_rec_mem
   import rsu_pkg::*;
(
   // clock and control
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // record push
   input wire logic push_i,
   input wire rsu_rec_t rec_i,
   // read port
   input wire logic rd_en_i,
   input wire logic rd_idx_i,
   output rsu_rec_t rd_o
);

   // ----------------------------------------
   // storage
   // ----------------------------------------
   rsu_rec_t mem [2];  // entry 0 newest, entry 1 older

   // push shifts the newest record into the older slot
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mem[0] <= '0;
         mem[1] <= '0;
      end else if (ce_i && push_i) begin
         mem[1] <= mem[0];
         mem[0] <= rec_i;
      end
   end

   // registered read
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rd_o <= '0;
      end else if (ce_i && rd_en_i) begin
         rd_o <= mem[rd_idx_i];
      end
   end

endmodule

// File: logic/rsu_seq.sv
// rsu sequencer: cause tracking, control sequencing and readouts
`timescale 1ns/100ps
module rsu_seq
   import rsu_pkg::*;
(
   // clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // reconfiguration causes, active high
   input wire logic external_config_reset_i,
   input wire logic config_error_pin_i,
   input wire logic crc_error_i,
   input wire logic user_watchdog_i,
   input wire logic fabric_reconfig_request_i,
   // configuration engine
   input wire logic load_done_i,
   // update register write
   input wire logic upd_wr_i,
   input wire rsu_ctl_t upd_data_i,
   // readout
   input wire logic rd_req_i,
   input wire logic [2:0] rd_sel_i,
   output logic [31:0] rd_data_o,
   output logic rd_valid_o,
   // sequencer outputs
   output rsu_ctl_t control_o,
   output logic [1:0] master_state_o,
   output logic reconfig_o
);

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   typedef enum logic [1:0] {
      SQ_RUN,      // image running, watching causes
      SQ_CAPTURE,  // status written, control being set
      SQ_LOAD      // image loading
   } rsu_sq_t;

   rsu_sq_t state;           // sequencer state
   rsu_sq_t next_state;      // sequencer next state
   rsu_ctl_t upd_q;          // update register
   rsu_cause_t cause_q;      // status register cause
   logic target_app;         // next image is an application
   logic app_seen;           // an application has run
   logic [3:0] hold_cnt;     // request high time
   logic fab_done;           // request already served
   logic rd_p1;              // readout stage one valid
   logic [2:0] sel_p1;       // readout stage one select
   rsu_rec_t rec_rd;         // record read data
   rsu_cause_t raw;          // causes this cycle
   rsu_cause_t win;          // winning cause
   rsu_rec_t rec_new;        // record of leaving image
   logic trig;               // a cause is taken
   logic push;               // record is written
   logic fab_fire;           // request held long enough
   logic in_run;             // state is run
   logic in_app;             // application running
   logic upd_ok;             // update write allowed
   logic [31:0] cur1_w;      // current readout one
   logic [31:0] cur2_w;      // current readout two
   logic [31:0] prev_w;      // record readout
   logic [31:0] rd_mux;      // selected readout

   // ----------------------------------------
   // cause decode
   // ----------------------------------------
   assign in_run = (state == SQ_RUN);
   assign in_app = (master_state_o == MS_APP);
   // request is served once it has stood its full hold time
   assign fab_fire = fabric_reconfig_request_i && in_run &&
                     !fab_done && (hold_cnt == HOLD_LAST);
   // all five causes, the watchdog only in a running application
   assign raw = {external_config_reset_i,
                 crc_error_i,
                 config_error_pin_i,
                 user_watchdog_i && in_run && in_app,
                 fab_fire};
   assign win = pick_cause(raw);
   assign trig = (state != SQ_CAPTURE) && (raw != CAUSE_NONE);
   // only leaving a running application makes a record
   assign push = trig && in_run && in_app;
   assign rec_new = {win,
                     master_state_o,
                     boot_of(control_o)};
   assign upd_ok = upd_wr_i && in_run &&
                   (master_state_o == MS_FACTORY);

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   // next state: capture lasts one cycle, load waits for done
   always_comb begin
      next_state = state;
      unique case (state)
         SQ_RUN: begin
            if (trig) begin
               next_state = SQ_CAPTURE;
            end
         end
         SQ_CAPTURE: begin
            next_state = SQ_LOAD;
         end
         SQ_LOAD: begin
            if (trig) begin
               next_state = SQ_CAPTURE;   // new cause restarts
            end else if (load_done_i) begin
               next_state = SQ_RUN;
            end
         end
         default: begin
            next_state = SQ_RUN;          // unused code recovers
         end
      endcase
   end

   // state register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= SQ_RUN;
      end else if (ce_i) begin
         state <= next_state;
      end
   end

   // status register written as soon as a cause is taken
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cause_q <= CAUSE_NONE;
         target_app <= 1'b0;
      end else if (ce_i && trig) begin
         cause_q <= win;
         target_app <= win.fab;
      end
   end

   // control set one cycle after the status, before the load
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         control_o <= CTL_RESET;
         reconfig_o <= 1'b0;
      end else if (ce_i) begin
         reconfig_o <= (state == SQ_CAPTURE);
         if (state == SQ_CAPTURE) begin
            // fabric copies update, any error clears
            control_o <= cause_q.fab ? upd_q : CTL_RESET;
         end
      end
   end

   // master state follows the image that finished loading
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         master_state_o <= MS_FACTORY;
         app_seen <= 1'b0;
      end else if (ce_i && state == SQ_LOAD && load_done_i &&
                   !trig) begin
         master_state_o <= target_app ? MS_APP : MS_FACTORY;
         app_seen <= app_seen | target_app;
      end
   end

   // update register, writable in factory only
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         upd_q <= UPD_RESET;
      end else if (ce_i && upd_ok) begin
         upd_q <= upd_data_i;
      end
   end

   // request hold counter, cleared whenever the request drops
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hold_cnt <= 4'h0;
         fab_done <= 1'b0;
      end else if (ce_i) begin
         if (!fabric_reconfig_request_i) begin
            hold_cnt <= 4'h0;
            fab_done <= 1'b0;
         end else begin
            if (hold_cnt != HOLD_LAST) begin
               hold_cnt <= hold_cnt + 4'h1;
            end
            if (fab_fire) begin
               fab_done <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------
   // record store
   // ----------------------------------------
   rsu_rec_mem u_rec (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .push_i(push),
      .rec_i(rec_new),
      .rd_en_i(rd_req_i),
      .rd_idx_i(rd_sel_i == SEL_PREV2),
      .rd_o(rec_rd)
   );

   // ----------------------------------------
   // readout
   // ----------------------------------------
   // factory view and second application view share a layout
   assign cur2_w = {master_state_o, PAD6,
                    boot_of(control_o)};
   assign cur1_w = in_app ?
                   {master_state_o, control_o.wd_en,
                    wd_value(control_o)} :
                   cur2_w;
   assign prev_w = app_seen ? {1'b0, rec_rd} :
                   INVALID_WORD;
   assign rd_mux = (sel_p1 == SEL_CUR1) ? cur1_w :
                   (sel_p1 == SEL_CUR2) ? cur2_w :
                   (sel_p1 == SEL_PREV1) ? prev_w :
                   (sel_p1 == SEL_PREV2) ? prev_w :
                   (sel_p1 == SEL_CAUSE) ? {PAD27, cause_q} :
                   32'h00000000;

   // two-stage readout pipeline, data from a flop
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rd_p1 <= 1'b0;
         sel_p1 <= SEL_CUR1;
         rd_valid_o <= 1'b0;
         rd_data_o <= 32'h00000000;
      end else if (ce_i) begin
         rd_p1 <= rd_req_i;
         sel_p1 <= rd_sel_i;
         rd_valid_o <= rd_p1;
         if (rd_p1) begin
            rd_data_o <= rd_mux;
         end
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking dc @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // independent count of request cycles, for the hold check only
   logic [4:0] req_age;  // cycles the request has stood so far
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         req_age <= 5'h00;
      end else if (ce_i) begin
         if (!fabric_reconfig_request_i) begin
            req_age <= 5'h00;
         end else if (req_age != 5'h1f) begin
            req_age <= req_age + 5'h01;
         end
      end
   end

   sequence both_causes_s;
      ce_i && in_run && external_config_reset_i && fab_fire;
   endsequence

   sequence cap_fab_s;
      ce_i && state == SQ_CAPTURE && cause_q.fab;
   endsequence

   sequence cap_err_s;
      ce_i && state == SQ_CAPTURE && !cause_q.fab;
   endsequence

   sequence rd_prev_s;
      ce_i && rd_req_i && !app_seen &&
      (rd_sel_i == SEL_PREV1 || rd_sel_i == SEL_PREV2);
   endsequence

   sequence rd_app1_s;
      ce_i && rd_req_i && rd_sel_i == SEL_CUR1 && in_app;
   endsequence

   ext_wins_a: assert property (
      both_causes_s |=> cause_q == 5'h10 && state == SQ_CAPTURE)
      else $error("external reset did not win over fabric request");

   ctl_copy_a: assert property (
      cap_fab_s |=> control_o == $past(upd_q) && reconfig_o)
      else $error("control did not take update before load");

   ctl_clear_a: assert property (
      cap_err_s |=> control_o == CTL_RESET && reconfig_o)
      else $error("control not cleared after error cause");

   status_first_a: assert property (
      $rose(reconfig_o) |-> $onehot(cause_q) &&
      $past(state) == SQ_CAPTURE && state == SQ_LOAD)
      else $error("load began without a recorded cause");

   upd_lock_a: assert property (
      (upd_wr_i && master_state_o != MS_FACTORY) |=> $stable(upd_q))
      else $error("update register written outside factory");

   hold_time_a: assert property (
      fab_fire |-> fabric_reconfig_request_i &&
      req_age >= 5'(REQ_HOLD_CYC - 1))
      else $error("fabric request served before hold time");

   inval_prev_a: assert property (
      rd_prev_s ##1 (ce_i && !app_seen) |=>
      rd_valid_o && rd_data_o == INVALID_WORD)
      else $error("early record read gave no invalid marker");

   app1_fmt_a: assert property (
      rd_app1_s ##1 (ce_i && in_app) |=>
      rd_valid_o && rd_data_o[31:30] == MS_APP &&
      rd_data_o[16:0] == WD_LOW)
      else $error("application readout one badly formed");

   rec_hot_a: assert property (
      push |-> $onehot(rec_new.cause) &&
      rec_new.mstate == MS_APP)
      else $error("record cause field is not one-hot");

   mode_sel_a: assert property (
      (ce_i && state == SQ_LOAD && load_done_i && !trig) |=>
      master_state_o == ($past(target_app) ? MS_APP : MS_FACTORY))
      else $error("wrong image mode after load");

   ms_hold_a: assert property (
      !(ce_i && state == SQ_LOAD && load_done_i && !trig) |=>
      $stable(master_state_o))
      else $error("master state moved without a finished load");

   rd_lat_a: assert property (
      (ce_i && rd_req_i) ##1 ce_i |=> rd_valid_o)
      else $error("readout valid did not follow its request");

   pulse_one_a: assert property (
      (ce_i && reconfig_o) |=> !reconfig_o)
      else $error("load start pulse lasted over one cycle");

   upd_take_a: assert property (
      (ce_i && upd_ok) |=> upd_q == $past(upd_data_i))
      else $error("allowed update write did not land");

endmodule

// File: tb/rsu_user_model.sv
// rsu user model: fabric logic that loads update and requests reconfig
`timescale 1ns/100ps
module rsu_user_model
   import rsu_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // commands from the bench
   input wire logic wr_go_i,
   input wire rsu_ctl_t wr_data_i,
   input wire logic req_go_i,
   input wire logic [4:0] hold_i,
   // towards the sequencer
   output logic upd_wr_o,
   output rsu_ctl_t upd_data_o,
   output logic req_o
);
   // -----------------------------
   // update write and request hold
   // -----------------------------
   logic [4:0] cnt; // cycles of request left

   // idle data bus toggles so a stray sample shows up
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         upd_wr_o <= 1'b0;
         upd_data_o <= '0;
         req_o <= 1'b0;
         cnt <= 5'h00;
      end else begin
         upd_wr_o <= wr_go_i;
         upd_data_o <= wr_go_i ? wr_data_i : ~upd_data_o;
         if (req_go_i) begin
            req_o <= 1'b1;
            cnt <= hold_i - 5'h01;
         end else if (cnt != 5'h00) begin
            cnt <= cnt - 5'h01; // hold level
         end else begin
            req_o <= 1'b0; // release after hold
         end
      end
   end
endmodule

// File: tb/remote_upgrade_status_sequencer_tb.sv
// testbench of the upgrade sequencer with a fabric user model
`timescale 1ns/100ps
module remote_upgrade_status_sequencer_tb
   import rsu_pkg::*;
;
   // -----------------------------
   // signals
   // -----------------------------
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1; // clock enable of the sequencer
   rsu_cause_t cz = '0; // bench-driven causes
   logic load_done = 1'b0;
   logic rd_req = 1'b0;
   logic [2:0] rd_sel = 3'h0;
   logic wr_go = 1'b0;
   rsu_ctl_t wr_data = '0;
   logic req_go = 1'b0;
   logic [4:0] hold = 5'h0d;
   logic upd_wr;
   rsu_ctl_t upd_data;
   logic fab_req;
   logic [31:0] rd_data;
   logic rd_valid;
   rsu_ctl_t control;
   logic [1:0] mstate;
   logic reconfig;
   int err_count = 0;
   int checked = 0;
   int n_reconf = 0; // reconfig pulses seen
   int base;
   rsu_cause_t c;
   localparam rsu_ctl_t U1 = {5'h0e, 22'h2a5a5, 12'habc}; // first app
   localparam rsu_ctl_t U2 = {5'h1c, 22'h15555, 12'h123}; // refused

   always #10 clk = ~clk; // 50 MHz

   // -----------------------------
   // instances
   // -----------------------------
   rsu_user_model i_user (.clk_i(clk), .rst_i(rst), .wr_go_i(wr_go),
      .wr_data_i(wr_data), .req_go_i(req_go), .hold_i(hold),
      .upd_wr_o(upd_wr), .upd_data_o(upd_data), .req_o(fab_req));

   rsu_seq i_dut (.clk_i(clk), .rst_i(rst), .ce_i(ce),
      .external_config_reset_i(cz.ext), .config_error_pin_i(cz.pin),
      .crc_error_i(cz.crc), .user_watchdog_i(cz.wd),
      .fabric_reconfig_request_i(fab_req), .load_done_i(load_done),
      .upd_wr_i(upd_wr), .upd_data_i(upd_data), .rd_req_i(rd_req),
      .rd_sel_i(rd_sel), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
      .control_o(control), .master_state_o(mstate),
      .reconfig_o(reconfig));

   // count load start pulses
   always @(posedge clk) begin
      if (reconfig === 1'b1) begin
         n_reconf++;
      end
   end

   // -----------------------------
   // tasks
   // -----------------------------
   // compare and count
   task automatic chk(input string nm, input logic [38:0] exp,
         input logic [38:0] got);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // verdict and end of run
   task automatic final_report();
      if (err_count == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // readout request, wait for valid, compare
   task automatic rd(input logic [2:0] sel, input logic [31:0] exp,
         input string nm);
      @(posedge clk);
      rd_req <= 1'b1;
      rd_sel <= sel;
      @(posedge clk);
      rd_req <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         #1;
         if (rd_valid === 1'b1) begin
            break;
         end
      end
      chk({nm, " valid"}, 39'h1, {38'h0, rd_valid});
      chk(nm, {7'h00, exp}, {7'h00, rd_data});
   endtask

   // user model loads the update register
   task automatic wr_upd(input rsu_ctl_t d);
      @(posedge clk);
      wr_go <= 1'b1;
      wr_data <= d;
      @(posedge clk);
      wr_go <= 1'b0;
      repeat (2) @(posedge clk);
   endtask

   // one trigger, then load done, check control and mode
   task automatic cause(input rsu_cause_t k, input rsu_ctl_t exp_ctl,
         input logic [1:0] exp_ms);
      @(posedge clk);
      if (k.fab) begin
         req_go <= 1'b1;
      end else begin
         cz <= k;
      end
      @(posedge clk);
      req_go <= 1'b0;
      cz <= '0;
      // a tie: other causes meet the firing edge of a 13-cycle hold
      if (k.fab && k[4:1] != 4'h0) begin
         repeat (12) @(posedge clk);
         cz <= {k[4:1], 1'b0};
         @(posedge clk);
         cz <= '0;
      end
      for (int i = 0; i < 40; i++) begin
         @(posedge clk);
         #1;
         if (reconfig === 1'b1) begin
            break;
         end
      end
      chk("load start", 39'h1, {38'h0, reconfig});
      chk("control", exp_ctl, control);
      @(posedge clk);
      load_done <= 1'b1;
      @(posedge clk);
      load_done <= 1'b0;
      #1;
      chk("mode", {37'h0, exp_ms}, {37'h0, mstate});
      repeat (14) @(posedge clk);
   endtask

   // -----------------------------
   // main sequence
   // -----------------------------
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rd(SEL_CUR1, {MS_FACTORY, 6'h00, 24'h000000}, "cur1 fac");
      rd(SEL_PREV1, 32'hffffffff, "prev1 early");
      rd(SEL_CAUSE, 32'h0, "cause none");
      wr_upd(U1);
      // request one cycle short of the hold is ignored
      base = n_reconf;
      hold <= 5'h0c;
      @(posedge clk);
      req_go <= 1'b1;
      @(posedge clk);
      req_go <= 1'b0;
      repeat (30) @(posedge clk);
      chk("short req", 39'h0, 39'(n_reconf - base));
      hold <= 5'h0d;
      cause(5'h01, U1, MS_APP);
      rd(SEL_CUR1, {MS_APP, U1.wd_en, U1.wd_timer, WD_LOW}, "cur1 app");
      rd(SEL_CUR2, {MS_APP, 6'h00, U1.ru_address, 2'h0}, "cur2 app");
      rd(SEL_CAUSE, 32'h01, "cause fab");
      wr_upd(U2);
      cause(5'h18, '0, MS_FACTORY);
      rd(SEL_CAUSE, 32'h10, "cause tie");
      // frozen enable holds the readout pipe until it returns
      @(posedge clk);
      rd_req <= 1'b1;
      rd_sel <= SEL_CAUSE;
      @(posedge clk);
      rd_req <= 1'b0;
      ce <= 1'b0;
      @(posedge clk);
      #1;
      chk("frozen valid", 39'h0, {38'h0, rd_valid});
      @(posedge clk);
      ce <= 1'b1;
      @(posedge clk);
      #1;
      chk("thawed valid", 39'h1, {38'h0, rd_valid});
      chk("thawed data", 39'h10, {7'h00, rd_data});
      rd(SEL_PREV1, {1'b0, 5'h10, MS_APP, U1.ru_address, 2'h0},
         "prev1 ext");
      cause(5'h01, U1, MS_APP);
      cause(5'h02, '0, MS_FACTORY);
      rd(SEL_PREV1, {1'b0, 5'h02, MS_APP, U1.ru_address, 2'h0},
         "prev1 wd");
      rd(SEL_PREV2, {1'b0, 5'h10, MS_APP, U1.ru_address, 2'h0},
         "prev2 ext");
      // remaining error causes from factory mode
      for (int j = 2; j < 4; j++) begin
         c = 5'h01 << j;
         cause(c, '0, MS_FACTORY);
         rd(SEL_CAUSE, {27'h0, c}, "cause err");
      end
      // external reset and fabric request on one edge
      cause(5'h11, '0, MS_FACTORY);
      rd(SEL_CAUSE, 32'h10, "cause ext fab");
      final_report();
   end

   // hang guard well beyond the expected run
   initial begin
      #200000;
      err_count++;
      final_report();
   end
endmodule
